// File: verilog/dss_defs.svh
// Constants for the display sync and scan command decoder
// Behaviour
// - Code 34h or 3400h, no argument, switches frame sync off, held low.
// - Switch-off while already off changes nothing.
// - Code 35h or 3500h takes one byte; only bit 0 matters.
// - Switch-on enables sync; select 0 vertical blanking, 1 adds horizontal.
// - In sleep-in with sync enabled, the output is held low.
// - Code 36h or 3600h byte sets eight scan and colour order bits.
// - Code 38h or 3800h, no argument, requests leaving idle state.
// - After idle exit the panel shows full colour depth again.
// - Idle exit while already outside idle changes nothing.
// - Reset sets both partial rows to zero; the end row takes the last line one cycle later.
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH
`define DSS_CMD_SYNC_OFF 16'h3400
`define DSS_CMD_SYNC_ON 16'h3500
`define DSS_CMD_ACCESS 16'h3600
`define DSS_CMD_IDLE_EXIT 16'h3800
`define DSS_CMD_IDLE_ENTER 16'h3900
`define DSS_CMD_SHORT_MASK 16'h00ff
`define DSS_BLANK_SEL_BIT 0
`define DSS_RES_864 8'h70
`define DSS_RES_854 8'h6b
`define DSS_RES_800 8'h50
`define DSS_RES_720 8'h28
`define DSS_LAST_864 16'h035f
`define DSS_LAST_854 16'h0355
`define DSS_LAST_800 16'h031f
`define DSS_LAST_720 16'h02cf
`define DSS_LAST_640 16'h027f
`define DSS_ACCESS_RESET 8'h00
`define DSS_ROW_ZERO 16'h0000
`endif

// File: verilog/dss_pkg.sv
// Types for the display sync and scan command decoder
package dss_pkg;
    typedef struct packed {
        logic row_addr_order;
        logic col_addr_order;
        logic row_col_swap;
        logic vert_refresh_order;
        logic bgr_order;
        logic horiz_refresh_order;
        logic flip_horizontal;
        logic flip_vertical;
    } dss_access_s;
    typedef struct packed {
        logic [15:0] code;
        logic [7:0] param;
        logic has_param;
    } dss_cmd_s;
endpackage

// File: verilog/dss_sync_gen.sv
// Frame sync waveform generator from line and frame timing
`include "dss_defs.svh"
module dss_sync_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic sync_enable,
    input wire logic blank_both,
    input wire logic sleep_in,
    input wire logic vert_refresh_order,
    // Panel timing
    input wire logic vblank,
    input wire logic hblank,
    input wire logic frame_start,
    // Output
    output logic frame_sync_out
);
    logic order_latched_reg;
    logic level_next;

    // Order change only takes effect at a frame start to avoid a torn edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            order_latched_reg <= 1'b0;
        end else if (frame_start) begin
            order_latched_reg <= vert_refresh_order;
        end
    end

    always_comb begin
        level_next = vblank ^ order_latched_reg;
        if (blank_both) begin
            level_next = level_next | hblank;
        end
        if (!sync_enable || sleep_in) begin
            level_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_sync_out <= 1'b0;
        end else begin
            frame_sync_out <= level_next;
        end
    end
endmodule

// File: verilog/dss_cmd_decoder.sv
// Command decoder for frame sync, access control and idle exit
`include "dss_defs.svh"
module dss_cmd_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command port from the host interface logic
    input wire logic cmd_valid,
    input wire dss_pkg::dss_cmd_s cmd,
    input wire logic packet_if,
    // Display state
    input wire logic sleep_in,
    input wire logic [7:0] resolution_code,
    input wire logic partial_load,
    input wire logic [15:0] partial_start_in,
    input wire logic [15:0] partial_end_in,
    // Panel timing, from pins
    input wire logic vblank_pin,
    input wire logic hblank_pin,
    input wire logic frame_start_pin,
    // Status
    output logic sync_enabled,
    output logic blank_both,
    output logic idle_mode,
    output dss_pkg::dss_access_s access_cfg,
    output logic [15:0] partial_start_row,
    output logic [15:0] partial_end_row,
    output logic frame_sync_out
);
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [2:0] frame_prev_reg;
    logic [15:0] code;
    logic hit_off;
    logic hit_on;
    logic hit_access;
    logic hit_idle_exit;
    logic hit_idle_enter;
    logic [15:0] last_line;
    logic rows_cleared;
    logic sync_enabled_reg;
    logic sync_enabled_next;
    logic blank_both_reg;
    logic blank_both_next;
    logic idle_mode_reg;
    logic idle_mode_next;
    dss_pkg::dss_access_s access_cfg_reg;
    dss_pkg::dss_access_s access_cfg_next;
    logic [15:0] partial_start_row_reg;
    logic [15:0] partial_start_row_next;
    logic [15:0] partial_end_row_reg;
    logic [15:0] partial_end_row_next;

    // Pins cross into the clock domain through two flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {frame_start_pin, hblank_pin, vblank_pin};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_prev_reg <= 3'h0;
        end else begin
            frame_prev_reg <= pin_sync_reg;
        end
    end

    // Packet links send the short code in the low byte
    always_comb begin
        code = cmd.code;
        if (packet_if) begin
            code = {cmd.code[7:0], 8'h00};
        end
    end

    // Commands compare in the long form; unknown codes fall through
    always_comb begin
        hit_off = 1'h0;
        hit_on = 1'h0;
        hit_access = 1'h0;
        hit_idle_exit = 1'h0;
        hit_idle_enter = 1'h0;
        // No state gating: every command is accepted in every mode
        if (cmd_valid) begin
            case (code)
                `DSS_CMD_SYNC_OFF: begin
                    hit_off = 1'h1;
                end
                `DSS_CMD_SYNC_ON: begin
                    hit_on = cmd.has_param;
                end
                `DSS_CMD_ACCESS: begin
                    hit_access = cmd.has_param;
                end
                `DSS_CMD_IDLE_EXIT: begin
                    hit_idle_exit = 1'h1;
                end
                `DSS_CMD_IDLE_ENTER: begin
                    hit_idle_enter = 1'h1;
                end
                default: begin
                    // Unknown codes leave every setting alone
                end
            endcase
        end
    end

    // Switch-off keeps the blanking mode; the next switch-on loads it again from bit 0
    always_comb begin
        sync_enabled_next = sync_enabled_reg;
        if (hit_off) begin
            sync_enabled_next = 1'h0;
        end else if (hit_on) begin
            sync_enabled_next = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_enabled_reg <= 1'h0;
        end else begin
            sync_enabled_reg <= sync_enabled_next;
        end
    end

    // Only bit 0 of the byte matters; the rest is ignored
    always_comb begin
        blank_both_next = blank_both_reg;
        if (hit_on) begin
            blank_both_next = cmd.param[`DSS_BLANK_SEL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blank_both_reg <= 1'h0;
        end else begin
            blank_both_reg <= blank_both_next;
        end
    end

    always_comb begin
        access_cfg_next = access_cfg_reg;
        if (hit_access) begin
            access_cfg_next = cmd.param;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            access_cfg_reg <= `DSS_ACCESS_RESET;
        end else begin
            access_cfg_reg <= access_cfg_next;
        end
    end

    // Clearing an already clear flag is harmless, so no extra check
    always_comb begin
        idle_mode_next = idle_mode_reg;
        if (hit_idle_exit) begin
            idle_mode_next = 1'h0;
        end else if (hit_idle_enter) begin
            idle_mode_next = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_mode_reg <= 1'h0;
        end else begin
            idle_mode_reg <= idle_mode_next;
        end
    end

    always_comb begin
        unique case (resolution_code)
            `DSS_RES_864: last_line = `DSS_LAST_864;
            `DSS_RES_854: last_line = `DSS_LAST_854;
            `DSS_RES_800: last_line = `DSS_LAST_800;
            `DSS_RES_720: last_line = `DSS_LAST_720;
            default: last_line = `DSS_LAST_640;
        endcase
    end

    // Both rows at zero stand for the default area
    assign rows_cleared = partial_start_row_reg == `DSS_ROW_ZERO
        && partial_end_row_reg == `DSS_ROW_ZERO;

    // Range is the host's duty; values are stored as given
    always_comb begin
        partial_start_row_next = partial_start_row_reg;
        if (partial_load) begin
            partial_start_row_next = partial_start_in;
        end
    end

    // A cleared area, after reset or by the host, takes the last line
    always_comb begin
        partial_end_row_next = partial_end_row_reg;
        if (partial_load) begin
            partial_end_row_next = partial_end_in;
        end else if (rows_cleared) begin
            partial_end_row_next = last_line;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            partial_start_row_reg <= `DSS_ROW_ZERO;
            partial_end_row_reg <= `DSS_ROW_ZERO;
        end else begin
            partial_start_row_reg <= partial_start_row_next;
            partial_end_row_reg <= partial_end_row_next;
        end
    end

    // Status outputs come straight from their flops
    assign sync_enabled = sync_enabled_reg;
    assign blank_both = blank_both_reg;
    assign idle_mode = idle_mode_reg;
    assign access_cfg = access_cfg_reg;
    assign partial_start_row = partial_start_row_reg;
    assign partial_end_row = partial_end_row_reg;

    dss_sync_gen u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .sync_enable(sync_enabled),
        .blank_both(blank_both),
        .sleep_in(sleep_in),
        .vert_refresh_order(access_cfg.vert_refresh_order),
        .vblank(frame_prev_reg[0]),
        .hblank(frame_prev_reg[1]),
        .frame_start(frame_prev_reg[2]),
        .frame_sync_out(frame_sync_out)
    );
endmodule

// File: testbench/dss_properties.sv
// Checker for the sync and scan command decoder
`include "dss_defs.svh"
module dss_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Inputs
    input wire logic cmd_valid,
    input wire dss_pkg::dss_cmd_s cmd,
    input wire logic packet_if,
    input wire logic sleep_in,
    input wire logic [7:0] resolution_code,
    input wire logic partial_load,
    // Outputs
    input wire logic sync_enabled,
    input wire logic blank_both,
    input wire logic idle_mode,
    input wire dss_pkg::dss_access_s access_cfg,
    input wire logic [15:0] partial_start_row,
    input wire logic [15:0] partial_end_row,
    input wire logic frame_sync_out
);
    // Short form folded into the long form
    wire [15:0] k = packet_if ? {cmd.code[7:0], 8'h00} : cmd.code;
    wire off = cmd_valid && k == `DSS_CMD_SYNC_OFF;
    wire on = cmd_valid && k == `DSS_CMD_SYNC_ON && cmd.has_param;
    wire acc = cmd_valid && k == `DSS_CMD_ACCESS && cmd.has_param;
    wire ext = cmd_valid && k == `DSS_CMD_IDLE_EXIT;
    wire ent = cmd_valid && k == `DSS_CMD_IDLE_ENTER;
    wire [15:0] last = resolution_code == `DSS_RES_864 ? `DSS_LAST_864 :
        resolution_code == `DSS_RES_854 ? `DSS_LAST_854 :
        resolution_code == `DSS_RES_800 ? `DSS_LAST_800 :
        resolution_code == `DSS_RES_720 ? `DSS_LAST_720 : `DSS_LAST_640;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_off_cmd: assert property (off |=> !sync_enabled)
        else $error("sync on after off");
    // Five cycles cover the pin pipeline
    a_off_low: assert property (!sync_enabled [*5] |-> !frame_sync_out)
        else $error("sync out high while off");
    a_off_hold: assert property (!sync_enabled && !on |=> !sync_enabled)
        else $error("sync turned on by itself");
    a_on_mode: assert property (on |=> sync_enabled &&
        blank_both == $past(cmd.param[0])) else $error("bad on mode");
    a_sleep_low: assert property (sleep_in [*5] |-> !frame_sync_out)
        else $error("sync out high in sleep");
    a_access_set: assert property (acc |=> access_cfg == $past(cmd.param))
        else $error("access bits wrong");
    a_idle_exit: assert property (ext |=> !idle_mode)
        else $error("idle kept after exit");
    a_idle_stay: assert property (!idle_mode && !ent |=> !idle_mode)
        else $error("idle entered by itself");
    a_rows_dflt: assert property (partial_start_row == 16'h0000 &&
        partial_end_row == 16'h0000 && !partial_load |=> partial_end_row == last)
        else $error("end row not defaulted");
    c_on: cover property (on);
    c_exit: cover property (ext && idle_mode);
    c_sleep: cover property (sleep_in && sync_enabled);
endmodule
bind dss_cmd_decoder dss_properties u_dss_properties (.*);

// File: testbench/dss_host_model.sv
// Host side model issuing decoder commands
module dss_host_model (
    // Clock and mode
    input wire logic clk,
    input wire logic packet_if,
    // Command port
    output logic cmd_valid,
    output dss_pkg::dss_cmd_s cmd,
    // Partial rows
    output logic partial_load,
    output logic [15:0] partial_start_in,
    output logic [15:0] partial_end_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cmd_valid, cmd, partial_load} = '0;
        {partial_start_in, partial_end_in} = '0;
    end
    task send(input logic [15:0] c, input logic [7:0] p, input logic h);
        @(negedge clk);
        cmd_valid = 1'b1;
        // One whole byte per command, short form when packet
        cmd = '{packet_if ? {8'h00, c[15:8]} : c, p, h};
        @(negedge clk);
        cmd_valid = 1'b0;
        // Released bus shows garbage, not the last value
        cmd = ~cmd;
    endtask
    // Caller keeps rows within the last line
    task load(input logic [15:0] s, input logic [15:0] e);
        @(negedge clk);
        partial_load = 1'b1;
        {partial_start_in, partial_end_in} = {s, e};
        @(negedge clk);
        partial_load = 1'b0;
    endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the command decoder
`include "dss_defs.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, packet_if = 1'b0, sleep_in = 1'b0;
    logic cmd_valid, partial_load, sync_enabled, blank_both, idle_mode;
    logic vblank_pin = 1'b0, hblank_pin = 1'b0, frame_start_pin = 1'b0;
    logic frame_sync_out;
    logic [7:0] resolution_code = `DSS_RES_864;
    logic [15:0] partial_start_in, partial_end_in;
    logic [15:0] partial_start_row, partial_end_row;
    dss_pkg::dss_cmd_s cmd;
    dss_pkg::dss_access_s access_cfg;
    int miscompares = 0, comparisons = 0;
    always #25 clk = ~clk;
    dss_cmd_decoder u_dss_cmd_decoder (.*);
    dss_host_model u_dss_host_model (.*);
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task s(input logic [15:0] c, input logic [7:0] p, input logic h);
        u_dss_host_model.send(c, p, h);
    endtask
    task give_verdict;
        if (miscompares == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        wt(20);
        rst_n = 1'b1;
        wt(2);
        `CHK("start", 16'h0000, partial_start_row)
        `CHK("end", `DSS_LAST_864, partial_end_row)
        s(`DSS_CMD_SYNC_OFF, 8'h00, 1'b0);
        `CHK("off", 1'b0, sync_enabled)
        s(`DSS_CMD_SYNC_ON, 8'h01, 1'b1);
        `CHK("both", 1'b1, blank_both)
        hblank_pin = 1'b1;
        wt(5);
        `CHK("h out", 1'b1, frame_sync_out)
        // Upper bits are don't care
        s(`DSS_CMD_SYNC_ON, 8'hfe, 1'b1);
        wt(5);
        `CHK("v only", 1'b0, frame_sync_out)
        vblank_pin = 1'b1;
        wt(5);
        `CHK("v out", 1'b1, frame_sync_out)
        sleep_in = 1'b1;
        wt(5);
        `CHK("sleep", 1'b0, frame_sync_out)
        s(`DSS_CMD_SYNC_OFF, 8'h00, 1'b0);
        `CHK("en", 1'b0, sync_enabled)
        sleep_in = 1'b0;
        wt(5);
        `CHK("off out", 1'b0, frame_sync_out)
        // A repeated switch-off must not touch the blanking mode
        s(`DSS_CMD_SYNC_ON, 8'h01, 1'b1);
        s(`DSS_CMD_SYNC_OFF, 8'h00, 1'b0);
        s(`DSS_CMD_SYNC_OFF, 8'h00, 1'b0);
        `CHK("keep", 1'b1, blank_both)
        `CHK("still off", 1'b0, sync_enabled)
        for (int i = 0; i < 8; i++) begin
            packet_if = i[0];
            s(`DSS_CMD_ACCESS, 8'h01 << i, 1'b1);
            `CHK("access", 8'h01 << i, access_cfg)
        end
        packet_if = 1'b0;
        s(`DSS_CMD_ACCESS, 8'h0f, 1'b0);
        s(16'h3700, 8'h0f, 1'b1);
        `CHK("refused", 8'h80, access_cfg)
        // Reversed vertical order flips the sync from the next frame
        s(`DSS_CMD_ACCESS, 8'h10, 1'b1);
        s(`DSS_CMD_SYNC_ON, 8'h00, 1'b1);
        {vblank_pin, hblank_pin, frame_start_pin} = 3'h1;
        wt(6);
        `CHK("order", 1'b1, frame_sync_out)
        frame_start_pin = 1'b0;
        s(`DSS_CMD_IDLE_ENTER, 8'h00, 1'b0);
        `CHK("enter", 1'b1, idle_mode)
        s(`DSS_CMD_IDLE_EXIT, 8'h00, 1'b0);
        `CHK("exit", 1'b0, idle_mode)
        s(`DSS_CMD_IDLE_EXIT, 8'h00, 1'b0);
        `CHK("again", 1'b0, idle_mode)
        resolution_code = `DSS_RES_854;
        u_dss_host_model.load(16'h0010, `DSS_LAST_854);
        `CHK("row", 16'h0010, partial_start_row)
        u_dss_host_model.load(16'h0000, 16'h0000);
        wt(1);
        `CHK("end 854", `DSS_LAST_854, partial_end_row)
        // Reset in mid-run must restore the defaults
        u_dss_host_model.load(16'h0010, 16'h0100);
        rst_n = 1'b0;
        wt(2);
        rst_n = 1'b1;
        wt(2);
        `CHK("rst start", 16'h0000, partial_start_row)
        `CHK("rst end", `DSS_LAST_854, partial_end_row)
        `CHK("rst sync", 1'b0, sync_enabled)
        `CHK("rst access", 8'h00, access_cfg)
        give_verdict();
    end
endmodule
